//--- inc/spi_nand_pkg.sv
package spi_nand_pkg;

    // data path
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_W = 6;

    // address layout
    localparam int COL_W = 12;
    localparam int ROW_W = 16;
    localparam int PAGE_SEL_W = 6;
    localparam int BLOCK_SEL_W = 10;
    localparam int PAGE_SEL_LSB = 0;
    localparam int BLOCK_SEL_LSB = 6;

    // page geometry in bytes
    localparam logic [11:0] MAIN_BYTES = 12'h0800;
    localparam logic [11:0] SPARE_BYTES = 12'h0080;
    localparam logic [11:0] ECC_SPARE_PROG = 12'h0040;
    localparam logic [11:0] COL_LAST = MAIN_BYTES + SPARE_BYTES - 12'h0001;
    localparam logic [11:0] ECC_PROG_END = MAIN_BYTES + ECC_SPARE_PROG;

    // protection field layout
    localparam int PROT_W = 5;
    localparam int PROT_B0 = 0;
    localparam int PROT_B1 = 1;
    localparam int PROT_B2 = 2;
    localparam int PROT_INV = 3;
    localparam int PROT_CMP = 4;
    localparam logic [4:0] PROT_RST = 5'h00;

    // shift step counts, last index per byte
    localparam logic [2:0] LAST_X1 = 3'h7;
    localparam logic [2:0] LAST_X2 = 3'h3;
    localparam logic [2:0] LAST_X4 = 3'h1;

    typedef enum logic [1:0] {
        LANE_X1 = 2'b00,
        LANE_X2 = 2'b01,
        LANE_X4 = 2'b10,
        LANE_DTR = 2'b11
    } lane_mode_t;

endpackage

//--- rtl/sync2.sv
`timescale 1ns/100ps
module sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

//--- rtl/fifo_buf.sv
`timescale 1ns/100ps
module fifo_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;

    wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire empty = (wp_q == rp_q);
    wire push = in_valid & ~full;
    wire pop = out_ready & ~empty;

    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = mem[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= push ? wp_q + 1'b1 : wp_q;
            rp_q <= pop ? rp_q + 1'b1 : rp_q;
        end
    end
endmodule

//--- rtl/serial_nand_host_interface.sv
`timescale 1ns/100ps
// Summary of operation
// R1: host keeps select high when idle, never floating after power-up
// R2: column index is 12 bits; only bytes 0 to 2175 are addressable
// R3: row bits 5..0 pick the page, bits 15..6 pick the block
// R4: ecc on: program first 64 spare bytes only, read all 128
// R5: ecc off: all 128 spare bytes readable and programmable
// R6: only serial modes 0 and 3 are supported
// R7: inputs sampled on rising clock edge, outputs launched on falling edge
// R8: host keeps serial clock static while select is high
// R9: select high with static clock means the interface is idle
// R10: dual commands use lanes 0 and 1 both ways, two bits per clock
// R11: quad commands add guard and pause pins as lanes 2 and 3
// R12: double-rate quad read launches output on both clock edges
// R13: double-rate commands run only with four-lane enable set
// R14: pause works only with four-lane enable clear
// R15: pause stops the serial side only, not array work in progress
// R16: pause starts and ends on pause pin edges, once clock is low
// R17: during pause outputs float, input and clock are ignored
// R18: select rising in pause resets logic; release pause before reselect
// R19: pin lock set and guard pin low refuses protection field writes
// R20: pin guarding applies only while four-lane enable is clear
// R21: strobe driven low on double-rate read, then follows clock with data
// R22: host captures double-rate data on both strobe edges
// R23: lanes and strobe float except in the device's own output phases; strobe driven whenever selected in double-rate mode with four-lane enable set
module serial_nand_host_interface #(
    parameter int FIFO_DEPTH = spi_nand_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial link pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic lane_0_in,
    output logic lane_0_out,
    output logic lane_0_oe,
    input wire logic lane_1_in,
    output logic lane_1_out,
    output logic lane_1_oe,
    input wire logic lane_2_in,
    output logic lane_2_out,
    output logic lane_2_oe,
    input wire logic lane_3_in,
    output logic lane_3_out,
    output logic lane_3_oe,
    output logic strobe_out,
    output logic strobe_oe,
    // configuration from the core
    input wire logic four_lane_enable,
    input wire logic protect_pin_lock,
    input wire logic ecc_enable,
    input wire spi_nand_pkg::lane_mode_t lane_mode,
    input wire logic out_phase,
    // received bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    // bytes to send
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // link status
    output logic selected,
    output logic paused,
    output logic dtr_refused,
    output logic tx_underrun,
    // address decode
    input wire logic [11:0] column_index,
    input wire logic [15:0] row_index,
    output logic [5:0] page_in_block,
    output logic [9:0] block_sel,
    output logic col_read_ok,
    output logic col_prog_ok,
    // protection fields
    input wire logic protect_wr_req,
    input wire logic [4:0] protect_wr_data,
    output logic protect_wr_refused,
    output logic protect_range_b0,
    output logic protect_range_b1,
    output logic protect_range_b2,
    output logic protect_invert,
    output logic protect_complement
);
    // pin synchronisation; idle-high pins cross inverted so reset reads them idle
    logic [5:0] pins_s;

    sync2 #(
        .WIDTH(spi_nand_pkg::SYNC_W)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({~cs_n, sclk, ~lane_3_in, ~lane_2_in, lane_1_in, lane_0_in}),
        .q(pins_s)
    );

    wire cs_s = ~pins_s[5];
    wire sclk_s = pins_s[4];
    wire pause_s = ~pins_s[3];
    wire guard_s = ~pins_s[2];
    wire l1_s = pins_s[1];
    wire l0_s = pins_s[0];

    // state
    logic sclk_q;
    logic sel_q;
    logic paused_q;
    logic blocked_q;
    logic [2:0] rx_cnt_q;
    logic [7:0] rx_sh_q;
    logic rx_valid_q;
    logic [7:0] rx_data_q;
    logic [2:0] tx_cnt_q;
    logic [7:0] tx_sh_q;
    logic underrun_q;
    logic strobe_q;
    logic [5:0] page_q;
    logic [9:0] block_q;
    logic col_rd_q;
    logic col_pg_q;
    logic [4:0] prot_q;
    logic refused_q;

    // mode decode
    wire x1 = (lane_mode == spi_nand_pkg::LANE_X1);
    wire x2 = (lane_mode == spi_nand_pkg::LANE_X2);
    wire is_dtr = (lane_mode == spi_nand_pkg::LANE_DTR);
    wire quad = ~x1 & ~x2;
    wire mode_ok = ~is_dtr | four_lane_enable; // [R13]
    wire [2:0] last_step = x1 ? spi_nand_pkg::LAST_X1 :
                           (x2 ? spi_nand_pkg::LAST_X2 : spi_nand_pkg::LAST_X4);

    // clock edges; either idle level works, so modes 0 and 3 both fit
    wire sclk_rise = sclk_s & ~sclk_q; // [R6]
    wire sclk_fall = ~sclk_s & sclk_q; // [R6]

    // edges count only while selected, not paused and the command allowed
    wire active = sel_q & ~paused_q & mode_ok; // [R8] [R17]
    wire rx_edge = active & ~out_phase & sclk_rise; // [R7]
    wire tx_edge = active & out_phase & (sclk_fall | (is_dtr & sclk_rise)); // [R7] [R12]

    // pause control, serial side only; the core and fifo keep running
    wire pause_ok = ~four_lane_enable & sel_q; // [R14] [R15]
    wire paused_d = ~pause_ok ? 1'b0 : (sclk_s ? paused_q : ~pause_s); // [R16]
    wire blocked_d = cs_s ? ((blocked_q | paused_q) & ~pause_s) : blocked_q; // [R18]
    wire sel_d = ~cs_s & ~blocked_q; // [R9] [R18]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_q <= 1'b0;
            sel_q <= 1'b0;
            paused_q <= 1'b0;
            blocked_q <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
            sel_q <= sel_d;
            paused_q <= paused_d;
            blocked_q <= blocked_d;
        end
    end

    // receive shifter
    wire [7:0] rx_sh_d = x1 ? {rx_sh_q[6:0], l0_s} :
                         (x2 ? {rx_sh_q[5:0], l1_s, l0_s} : // [R10]
                         {rx_sh_q[3:0], pause_s, guard_s, l1_s, l0_s}); // [R11]
    wire rx_last = (rx_cnt_q == last_step);
    wire rx_done = rx_edge & rx_last;
    wire [2:0] rx_cnt_d = ~sel_q ? 3'h0 :
                          (rx_edge ? (rx_last ? 3'h0 : rx_cnt_q + 3'h1) : rx_cnt_q);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_cnt_q <= 3'h0;
            rx_sh_q <= 8'h00;
        end else begin
            rx_cnt_q <= rx_cnt_d;
            rx_sh_q <= rx_edge ? rx_sh_d : rx_sh_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h00;
        end else begin
            rx_valid_q <= rx_done;
            rx_data_q <= rx_done ? rx_sh_d : rx_data_q;
        end
    end

    // transmit buffer
    logic f_valid;
    logic [7:0] f_data;
    wire tx_load = tx_edge & (tx_cnt_q == 3'h0);

    fifo_buf #(
        .WIDTH(spi_nand_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(f_valid),
        .out_ready(tx_load),
        .out_data(f_data)
    );

    // transmit shifter, msb first
    wire [7:0] tx_shift = x1 ? {tx_sh_q[6:0], 1'b0} :
                          (x2 ? {tx_sh_q[5:0], 2'b00} : {tx_sh_q[3:0], 4'h0});
    wire [7:0] tx_fill = f_valid ? f_data : 8'h00;
    wire tx_idle = ~sel_q | ~out_phase;
    wire [7:0] tx_sh_d = tx_idle ? 8'h00 :
                         (tx_load ? tx_fill : (tx_edge ? tx_shift : tx_sh_q));
    wire [2:0] tx_cnt_d = tx_idle ? 3'h0 :
                          (tx_load ? last_step : (tx_edge ? tx_cnt_q - 3'h1 : tx_cnt_q));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_sh_q <= 8'h00;
            tx_cnt_q <= 3'h0;
            underrun_q <= 1'b0;
        end else begin
            tx_sh_q <= tx_sh_d;
            tx_cnt_q <= tx_cnt_d;
            underrun_q <= tx_load & ~f_valid;
        end
    end

    // lane drivers
    wire drive = active & out_phase; // [R17] [R23]
    assign lane_3_out = tx_sh_q[7];
    assign lane_2_out = tx_sh_q[6];
    assign lane_1_out = quad ? tx_sh_q[5] : tx_sh_q[7];
    assign lane_0_out = quad ? tx_sh_q[4] : tx_sh_q[6];
    assign lane_1_oe = drive;
    assign lane_0_oe = drive & ~x1; // [R10]
    assign lane_2_oe = drive & quad; // [R11]
    assign lane_3_oe = drive & quad; // [R11]

    // read strobe: low once accepted, follows the clock while data flows
    wire strobe_en = sel_q & is_dtr & four_lane_enable; // [R21] [R23]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= strobe_en & out_phase & sclk_s; // [R21]
        end
    end
    assign strobe_oe = strobe_en;
    assign strobe_out = strobe_q;

    // address decode
    wire rd_ok = (column_index <= spi_nand_pkg::COL_LAST); // [R2] [R4] [R5]
    wire pg_ok = ecc_enable ? (column_index < spi_nand_pkg::ECC_PROG_END) : rd_ok; // [R4] [R5]
    wire [5:0] page_d = row_index[spi_nand_pkg::PAGE_SEL_LSB +: spi_nand_pkg::PAGE_SEL_W];
    wire [9:0] block_d = row_index[spi_nand_pkg::BLOCK_SEL_LSB +: spi_nand_pkg::BLOCK_SEL_W];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            page_q <= 6'h00;
            block_q <= 10'h000;
            col_rd_q <= 1'b0;
            col_pg_q <= 1'b0;
        end else begin
            page_q <= page_d; // [R3]
            block_q <= block_d; // [R3]
            col_rd_q <= rd_ok;
            col_pg_q <= pg_ok;
        end
    end

    // protection fields with pin guard
    wire guard_on = protect_pin_lock & ~guard_s & ~four_lane_enable; // [R19] [R20]
    wire prot_wr = protect_wr_req & ~guard_on;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prot_q <= spi_nand_pkg::PROT_RST;
            refused_q <= 1'b0;
        end else begin
            prot_q <= prot_wr ? protect_wr_data : prot_q; // [R19]
            refused_q <= protect_wr_req & guard_on; // [R19]
        end
    end

    // outputs
    assign rx_valid = rx_valid_q;
    assign rx_data = rx_data_q;
    assign selected = sel_q;
    assign paused = paused_q;
    assign dtr_refused = sel_q & ~mode_ok;
    assign tx_underrun = underrun_q;
    assign page_in_block = page_q;
    assign block_sel = block_q;
    assign col_read_ok = col_rd_q;
    assign col_prog_ok = col_pg_q;
    assign protect_wr_refused = refused_q;
    assign protect_range_b0 = prot_q[spi_nand_pkg::PROT_B0];
    assign protect_range_b1 = prot_q[spi_nand_pkg::PROT_B1];
    assign protect_range_b2 = prot_q[spi_nand_pkg::PROT_B2];
    assign protect_invert = prot_q[spi_nand_pkg::PROT_INV];
    assign protect_complement = prot_q[spi_nand_pkg::PROT_CMP];

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_pause_float: assert property ( // [R17]
        paused_q |-> !(lane_0_oe | lane_1_oe | lane_2_oe | lane_3_oe) && !rx_edge)
        else $error("lanes driven or sampled during pause");

    a_cs_idle: assert property ( // [R9]
        cs_s [*3] |-> !sel_q && !lane_1_oe && !strobe_oe && !rx_valid_q)
        else $error("interface active while select high");

    a_guard_refuse: assert property ( // [R19]
        protect_wr_req && protect_pin_lock && !guard_s && !four_lane_enable
        |=> $stable(prot_q) && protect_wr_refused)
        else $error("guarded protection write not refused");

    a_guard_qe_off: assert property ( // [R20]
        protect_wr_req && four_lane_enable
        |=> prot_q == $past(protect_wr_data) && !protect_wr_refused)
        else $error("guard applied with four-lane enable set");

    a_dtr_needs_qe: assert property ( // [R13]
        is_dtr && !four_lane_enable |-> !lane_1_oe && !strobe_oe && !rx_edge)
        else $error("double-rate command run without four-lane enable");

    a_row_split: assert property ( // [R3]
        ##1 1'b1 |-> block_sel == $past(row_index[15:6])
        && page_in_block == $past(row_index[5:0]))
        else $error("row index split wrong");

    a_spare_ecc: assert property ( // [R4]
        ecc_enable && column_index >= spi_nand_pkg::ECC_PROG_END
        && column_index <= spi_nand_pkg::COL_LAST |=> col_read_ok && !col_prog_ok)
        else $error("upper spare access wrong with ecc on");

    a_spare_raw: assert property ( // [R5]
        !ecc_enable && column_index <= spi_nand_pkg::COL_LAST |=> col_prog_ok && col_read_ok)
        else $error("spare not programmable with ecc off");

    a_col_bound: assert property ( // [R2]
        column_index > spi_nand_pkg::COL_LAST |=> !col_read_ok && !col_prog_ok)
        else $error("out of bounds column accepted");

    a_strobe_low: assert property ( // [R21]
        strobe_oe && !out_phase |=> !strobe_out)
        else $error("strobe toggles without output data");

    a_pause_qe: assert property ( // [R14]
        four_lane_enable |=> !paused_q)
        else $error("pause active with four-lane enable set");

    a_pause_clk_low: assert property ( // [R16]
        !paused_q && sclk_s |=> !paused_q)
        else $error("pause began while clock high");

    c_pause: cover property (paused_q ##1 !paused_q && sel_q);
    c_quad_byte: cover property (rx_valid_q && lane_mode == spi_nand_pkg::LANE_X4);
    c_dtr_strobe: cover property (strobe_oe && strobe_out ##1 strobe_oe && !strobe_out);
    c_blocked: cover property (blocked_q);
endmodule

//--- verif/host_model.sv
`timescale 1ns/100ps
module host_model (
    // link pins
    output logic cs_n,
    output logic sclk,
    output logic [3:0] lane_in,
    // device drivers
    input wire logic [3:0] lane_out,
    input wire logic [3:0] lane_oe
);
    logic [3:0] hv = 4'h0;
    logic [3:0] he = 4'h0;
    logic tog = 1'b0;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
    end
    // guard and pause pulled up, free data lanes flip each cycle
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane_in[i] = lane_oe[i] ? lane_out[i] : he[i] ? hv[i] : (i > 1) | (tog ^ i[0]);
        end
    end
    task automatic pin(input int i, input logic en, input logic v);
        he[i] = en;
        hv[i] = v;
    endtask
    task automatic park(input logic v);
        sclk = v;
        #200;
    endtask
    task automatic cs(input logic v);
        cs_n = v;
        #400;
    endtask
    // clock parked at the mode's idle level around select
    task automatic start(input logic cpol);
        park(cpol);
        cs(1'b0);
    endtask
    task automatic stop(input logic cpol);
        park(cpol);
        he = 4'h0;
        cs(1'b1);
    endtask
    // drive on the low half, device samples at the rising edge
    task automatic cyc(input logic [3:0] en, input logic [3:0] v, output logic [3:0] got);
        sclk = 1'b0;
        hv = (hv & ~en) | (v & en);
        he = he | en;
        tog = ~tog;
        #200;
        sclk = 1'b1;
        #200;
        got = lane_in;
    endtask
    // one byte msb first, w bits a cycle; x1 sends on lane 0, returns lane 1
    task automatic xfer(input int w, input logic drv, input logic [7:0] tx, output logic [7:0] rx);
        logic [3:0] g;
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        rx = 8'h00;
        for (int k = 8 - w; k >= 0; k -= w) begin
            cyc(drv ? m : 4'h0, 4'(tx >> k) & m, g);
            rx = (rx << w) | 8'((w == 1) ? 4'(g[1]) : g & m);
        end
    endtask
endmodule

//--- verif/serial_nand_host_interface_bench.sv
`timescale 1ns/100ps
module serial_nand_host_interface_bench;
    logic clk;
    logic nrst;
    wire cs_n, sclk;
    wire [3:0] l_in, l_out, l_oe;
    logic strobe_out, strobe_oe, rx_valid, tx_ready, selected, paused, dtr_refused, tx_underrun;
    logic col_read_ok, col_prog_ok, protect_wr_refused, protect_range_b0, protect_range_b1;
    logic protect_range_b2, protect_invert, protect_complement;
    logic [7:0] rx_data;
    logic [5:0] page_in_block;
    logic [9:0] block_sel;
    logic four_lane_enable, protect_pin_lock, ecc_enable, out_phase, tx_valid, protect_wr_req;
    logic [7:0] tx_data;
    logic [11:0] column_index;
    logic [15:0] row_index;
    logic [4:0] protect_wr_data;
    spi_nand_pkg::lane_mode_t lane_mode;
    int err_total = 0;
    int n_tests = 0;
    int n_under = 0;
    logic [31:0] seed = 32'h0000_0024;
    logic [7:0] rxq[$];
    logic [7:0] expq[$];
    logic [11:0] tab [8] = '{12'h000, 12'h7ff, 12'h800, 12'h83f, 12'h840, 12'h87f, 12'h880, 12'hfff};
    wire [4:0] pfs = {protect_complement, protect_invert, protect_range_b2, protect_range_b1,
        protect_range_b0};

    serial_nand_host_interface serial_nand_host_interface_i (
        .clk, .nrst, .cs_n, .sclk,
        .lane_0_in(l_in[0]), .lane_0_out(l_out[0]), .lane_0_oe(l_oe[0]),
        .lane_1_in(l_in[1]), .lane_1_out(l_out[1]), .lane_1_oe(l_oe[1]),
        .lane_2_in(l_in[2]), .lane_2_out(l_out[2]), .lane_2_oe(l_oe[2]),
        .lane_3_in(l_in[3]), .lane_3_out(l_out[3]), .lane_3_oe(l_oe[3]),
        .strobe_out, .strobe_oe, .four_lane_enable, .protect_pin_lock, .ecc_enable, .lane_mode,
        .out_phase, .rx_valid, .rx_data, .tx_valid, .tx_ready, .tx_data, .selected, .paused,
        .dtr_refused, .tx_underrun, .column_index, .row_index, .page_in_block, .block_sel,
        .col_read_ok, .col_prog_ok, .protect_wr_req, .protect_wr_data, .protect_wr_refused,
        .protect_range_b0, .protect_range_b1, .protect_range_b2, .protect_invert,
        .protect_complement
    );
    host_model host_model_i (.cs_n, .sclk, .lane_in(l_in), .lane_out(l_out), .lane_oe(l_oe));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(negedge clk) begin
        if (rx_valid === 1'b1)
            rxq.push_back(rx_data);
        if (tx_underrun === 1'b1)
            n_under++;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [1:0] col_ok(input logic ecc, input logic [11:0] c);
        return {c < 12'h880, ecc ? c < 12'h840 : c < 12'h880};
    endfunction
    task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_b(input string nm, input logic e, input logic g);
        chk_v(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic chk_rx();
        chk_v("rx_count", 16'(expq.size()), 16'(rxq.size()));
        while (expq.size() > 0 && rxq.size() > 0)
            chk_v("rx_data", 16'(expq.pop_front()), 16'(rxq.pop_front()));
        expq.delete();
        rxq.delete();
    endtask
    task automatic stop_test();
        $display("counts: %0d checks, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        stop_test();
    end

    initial begin
        logic [31:0] d;
        logic [7:0] g;
        logic [2:0] k;
        logic rf;
        int n;
        int w;
        nrst = 1'b0;
        {four_lane_enable, protect_pin_lock, ecc_enable, out_phase, tx_valid, protect_wr_req} = 6'h00;
        tx_data = 8'h00;
        column_index = 12'h000;
        row_index = 16'h0000;
        protect_wr_data = 5'h00;
        lane_mode = spi_nand_pkg::LANE_X1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        chk_v("oe_reset", 16'h0000, {11'h000, strobe_oe, l_oe});
        chk_b("tx_ready_reset", 1'b1, tx_ready);
        for (int i = 0; i < 40; i++) begin
            d = rnd();
            column_index = (i < 16) ? tab[i[3:1]] : d[11:0];
            ecc_enable = (i < 16) ? i[0] : d[12];
            row_index = d[31:16];
            @(negedge clk);
            chk_v("page_in_block", 16'(row_index[5:0]), 16'(page_in_block));
            chk_v("block_sel", 16'(row_index[15:6]), 16'(block_sel));
            chk_v("col_ok", 16'(col_ok(ecc_enable, column_index)),
                {14'h0000, col_read_ok, col_prog_ok});
        end
        $display("test address done");
        for (int i = 0; i < 16; i++) begin
            k = i[2:0];
            d = rnd();
            host_model_i.pin(2, 1'b1, k[1]);
            four_lane_enable = k[2];
            protect_pin_lock = k[0];
            repeat (4) @(negedge clk);
            protect_wr_data = d[4:0];
            protect_wr_req = 1'b1;
            @(negedge clk);
            protect_wr_req = 1'b0;
            rf = protect_wr_refused;
            @(negedge clk);
            rf = rf | protect_wr_refused;
            @(negedge clk);
            if (!(k[0] && !k[1] && !k[2]))
                expq.push_back(8'(d[4:0]));
            chk_b("protect_wr_refused", k[0] & ~k[1] & ~k[2], rf);
            if (expq.size() > 0)
                chk_v("protect_fields", 16'(expq[$]), 16'(pfs));
        end
        expq.delete();
        host_model_i.pin(2, 1'b0, 1'b0);
        $display("test protect done");
        for (int m = 0; m < 6; m++) begin
            @(negedge clk);
            w = (m < 2) ? 1 : (m == 2) ? 2 : 4;
            lane_mode = spi_nand_pkg::lane_mode_t'(m < 2 ? 0 : m > 4 ? 3 : m - 1);
            four_lane_enable = (m == 3 || m == 4);
            host_model_i.start(m == 1);
            if (m >= 4) begin
                chk_v("strobe", 16'(m == 4 ? 2 : 0), 16'({strobe_oe, strobe_out}));
                chk_b("dtr_refused", m == 5, dtr_refused);
            end
            for (int b = 0; b < 3; b++) begin
                d = rnd();
                host_model_i.xfer(w, 1'b1, d[7:0], g);
                if (m != 5)
                    expq.push_back(d[7:0]);
            end
            chk_v("oe_input", 16'h0000, 16'(l_oe));
            host_model_i.stop(m == 1);
            chk_b("idle", 1'b0, selected);
            chk_rx();
        end
        $display("test receive done");
        @(negedge clk);
        lane_mode = spi_nand_pkg::LANE_X1;
        four_lane_enable = 1'b0;
        n = 0;
        while (tx_ready === 1'b1 && n < 20) begin
            d = rnd();
            tx_data = d[7:0];
            tx_valid = 1'b1;
            expq.push_back(d[7:0]);
            n++;
            @(negedge clk);
        end
        tx_valid = 1'b0;
        chk_v("fifo_fill", 16'h0010, 16'(n));
        expq.push_back(8'h00);
        for (int p = 0; p < 2; p++) begin
            lane_mode = p ? spi_nand_pkg::LANE_X4 : spi_nand_pkg::LANE_X1;
            four_lane_enable = p[0];
            out_phase = 1'b1;
            host_model_i.start(1'b1);
            for (int b = 0; b < 8 + p; b++) begin
                host_model_i.xfer(p ? 4 : 1, 1'b0, 8'h00, g);
                chk_v("tx_byte", 16'(expq.pop_front()), 16'(g));
            end
            chk_v("oe_output", p ? 16'h000f : 16'h0002, 16'(l_oe));
            out_phase = 1'b0;
            host_model_i.stop(1'b1);
        end
        chk_v("underrun", 16'h0001, 16'(n_under));
        lane_mode = spi_nand_pkg::LANE_DTR;
        four_lane_enable = 1'b1;
        out_phase = 1'b1;
        host_model_i.start(1'b0);
        host_model_i.park(1'b1);
        chk_v("strobe_high", 16'h0003, 16'({strobe_oe, strobe_out}));
        chk_v("oe_dtr", 16'h000f, 16'(l_oe));
        host_model_i.park(1'b0);
        chk_v("strobe_low", 16'h0002, 16'({strobe_oe, strobe_out}));
        out_phase = 1'b0;
        host_model_i.stop(1'b0);
        $display("test transmit done");
        lane_mode = spi_nand_pkg::LANE_X1;
        four_lane_enable = 1'b0;
        host_model_i.start(1'b0);
        host_model_i.pin(3, 1'b1, 1'b0);
        repeat (6) @(negedge clk);
        chk_b("paused", 1'b1, paused);
        host_model_i.xfer(1, 1'b1, 8'ha5, g);
        chk_v("oe_paused", 16'h0000, 16'(l_oe));
        host_model_i.pin(3, 1'b1, 1'b1);
        repeat (6) @(negedge clk);
        chk_b("pause_holds_high_clock", 1'b1, paused);
        host_model_i.park(1'b0);
        chk_b("pause_ends", 1'b0, paused);
        host_model_i.xfer(1, 1'b1, 8'h3c, g);
        expq.push_back(8'h3c);
        host_model_i.park(1'b0);
        chk_rx();
        host_model_i.pin(3, 1'b1, 1'b0);
        repeat (6) @(negedge clk);
        host_model_i.cs(1'b1);
        host_model_i.cs(1'b0);
        chk_b("blocked", 1'b0, selected);
        host_model_i.pin(3, 1'b1, 1'b1);
        host_model_i.cs(1'b1);
        host_model_i.cs(1'b0);
        chk_b("reselect", 1'b1, selected);
        four_lane_enable = 1'b1;
        host_model_i.pin(3, 1'b1, 1'b0);
        repeat (6) @(negedge clk);
        chk_b("no_pause_quad", 1'b0, paused);
        host_model_i.stop(1'b0);
        $display("test pause done");
        stop_test();
    end
endmodule
